// file: design/gmf_pkg.sv
// Package for the 32-line port controller: register offsets,
// reset values and the map of lines that exist on this port.
// Assumes a 32-bit register port with byte offsets.
package gmf_pkg;

  localparam int unsigned NUM_LINES = 32;
  localparam int unsigned ADDR_W    = 8;

  // Lines that exist; absent lines ignore writes and read zero
  localparam logic [31:0] LINE_MASK = 32'hFFFFFFFF;

  // Register offsets
  localparam logic [7:0] OFS_DEGLITCH_SET   = 8'h20;
  localparam logic [7:0] OFS_DEGLITCH_CLEAR = 8'h24;
  localparam logic [7:0] OFS_DEGLITCH_STATE = 8'h28;
  localparam logic [7:0] OFS_DRIVE_HIGH     = 8'h30;
  localparam logic [7:0] OFS_DRIVE_LOW      = 8'h34;
  localparam logic [7:0] OFS_OUT_DATA       = 8'h38;
  localparam logic [7:0] OFS_PIN_LEVEL      = 8'h3C;
  localparam logic [7:0] OFS_IRQ_SET        = 8'h40;
  localparam logic [7:0] OFS_IRQ_CLEAR      = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK       = 8'h48;
  localparam logic [7:0] OFS_IRQ_FLAGS      = 8'h4C;
  localparam logic [7:0] OFS_OD_SET         = 8'h50;
  localparam logic [7:0] OFS_OD_CLEAR       = 8'h54;
  localparam logic [7:0] OFS_OD_STATE       = 8'h58;
  localparam logic [7:0] OFS_WMASK_SET      = 8'hA0;
  localparam logic [7:0] OFS_WMASK_CLEAR    = 8'hA4;
  localparam logic [7:0] OFS_WMASK_STATE    = 8'hA8;

  // Reset values
  localparam logic [31:0] RST_WMASK    = 32'h00000000;
  localparam logic [31:0] RST_OD       = 32'h00000000;
  localparam logic [31:0] RST_DEGLITCH = 32'h00000000;
  localparam logic [31:0] RST_IRQ_MASK = 32'h00000000;
  localparam logic [31:0] RST_FLAGS    = 32'h00000000;
  localparam logic [31:0] RST_OUT_DATA = 32'h00000000;
  localparam logic [31:0] RST_ZERO     = 32'h00000000;

endpackage : gmf_pkg

// file: design/gmf_in_line.sv
// One input line: three-stage synchroniser, optional deglitch
// stage and a level that freezes while the controller clock is off.
// Assumes pin_in is asynchronous to clk_in.
`timescale 1ns/1ns
module gmf_in_line
  import gmf_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Control
  input  wire logic clk_en_in,
  input  wire logic filter_en_in,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1, s2, s3;
  logic stable;
  logic next_stable, next_level;

  always_comb begin
    next_stable = stable;
    next_level  = level_out;
    if (clk_en_in) begin
      if (s2 == s3) begin
        next_stable = s3;
      end
      if (!filter_en_in) begin
        next_level = next_stable;
      end else if (next_stable == stable) begin
        next_level = next_stable;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1        <= 1'b0;
      s2        <= 1'b0;
      s3        <= 1'b0;
      stable    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1        <= pin_in;
      s2        <= s1;
      s3        <= s2;
      stable    <= next_stable;
      level_out <= next_level;
    end
  end

endmodule // gmf_in_line

// file: design/gmf_port.sv
// Top of the 32-line port controller: register port, masked output
// data, open-drain drive, pin level readback, deglitch and change flags.
// Assumes register strobes are synchronous to clk_in and single-cycle.
`timescale 1ns/1ns

module gmf_port
  import gmf_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              clk_en_in,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [31:0]       wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [31:0]       rdata_out,
  // Neighbour control: owner, enable, peripheral drive
  input  wire logic [31:0]       ctrl_owns_in,
  input  wire logic [31:0]       ctrl_oe_in,
  input  wire logic [31:0]       periph_oe_in,
  input  wire logic [31:0]       periph_data_in,
  // Pins
  input  wire logic [31:0]       pin_in,
  output logic      [31:0]       pin_out,
  output logic      [31:0]       pin_oe_n_out,
  // Output data to neighbours and interrupt
  output logic      [31:0]       output_data_state_out,
  output logic                   irq_out
);

  logic [31:0] output_data_state;
  logic [31:0] write_mask_state;
  logic [31:0] open_drain_state;
  logic [31:0] deglitch_state;
  logic [31:0] change_irq_mask;
  logic [31:0] change_irq_flags;
  logic [31:0] pin_level_state;
  logic [31:0] level_prev;

  logic [31:0] next_output_data_state;
  logic [31:0] next_write_mask_state;
  logic [31:0] next_open_drain_state;
  logic [31:0] next_deglitch_state;
  logic [31:0] next_change_irq_mask;
  logic [31:0] next_change_irq_flags;
  logic [31:0] next_level_prev;
  logic [31:0] next_rdata;
  logic        next_irq;
  logic [31:0] next_pin_out;
  logic [31:0] next_pin_oe_n;

  logic [31:0] wdata_m;
  logic [31:0] change;
  logic [31:0] drv_val;
  logic [31:0] drv_en;
  logic        wr_hit_any;
  logic        rd_flags;

  assign wdata_m  = wdata_in & LINE_MASK;
  assign rd_flags = rd_in && (addr_in == OFS_IRQ_FLAGS);

  // filtered path; peripherals see raw pins elsewhere
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      gmf_in_line gmf_in_line_inst (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .clk_en_in    (clk_en_in),
        .filter_en_in (deglitch_state[gi]),
        .pin_in       (pin_in[gi]),
        .level_out    (pin_level_state[gi])
      );
    end
  endgenerate

  always_comb begin
    change          = RST_ZERO;
    next_level_prev = level_prev;
    if (clk_en_in) begin
      change          = (pin_level_state ^ level_prev) & LINE_MASK;
      next_level_prev = pin_level_state;
    end
  end

  // Register state
  always_comb begin
    next_output_data_state = output_data_state;
    next_write_mask_state  = write_mask_state;
    next_open_drain_state  = open_drain_state;
    next_deglitch_state    = deglitch_state;
    next_change_irq_mask   = change_irq_mask;
    wr_hit_any             = 1'b0;
    if (wr_in) begin
      wr_hit_any = 1'b1;
      case (addr_in)
        OFS_DRIVE_HIGH: begin
          next_output_data_state = output_data_state | wdata_m;
        end
        OFS_DRIVE_LOW: begin
          next_output_data_state = output_data_state & ~wdata_m;
        end
        OFS_OUT_DATA: begin
          next_output_data_state = (output_data_state & ~write_mask_state)
                                 | (wdata_m & write_mask_state);
        end
        OFS_WMASK_SET: begin
          next_write_mask_state = write_mask_state | wdata_m;
        end
        OFS_WMASK_CLEAR: begin
          next_write_mask_state = write_mask_state & ~wdata_m;
        end
        OFS_OD_SET: begin
          next_open_drain_state = open_drain_state | wdata_m;
        end
        OFS_OD_CLEAR: begin
          next_open_drain_state = open_drain_state & ~wdata_m;
        end
        OFS_DEGLITCH_SET: begin
          next_deglitch_state = deglitch_state | wdata_m;
        end
        OFS_DEGLITCH_CLEAR: begin
          next_deglitch_state = deglitch_state & ~wdata_m;
        end
        OFS_IRQ_SET: begin
          next_change_irq_mask = change_irq_mask | wdata_m;
        end
        OFS_IRQ_CLEAR: begin
          next_change_irq_mask = change_irq_mask & ~wdata_m;
        end
        default: begin
          wr_hit_any = 1'b0;
        end
      endcase
    end
  end

  // Flags and interrupt; a change in the read cycle survives the clear
  always_comb begin
    next_change_irq_flags = (rd_flags ? RST_FLAGS : change_irq_flags) | change;
    next_irq = |(next_change_irq_flags & next_change_irq_mask);
  end

  // Read mux; write-only and unmapped offsets read zero
  always_comb begin
    next_rdata = RST_ZERO;
    if (rd_in) begin
      case (addr_in)
        OFS_OUT_DATA:       next_rdata = output_data_state;
        OFS_PIN_LEVEL:      next_rdata = pin_level_state & LINE_MASK;
        OFS_WMASK_STATE:    next_rdata = write_mask_state;
        OFS_OD_STATE:       next_rdata = open_drain_state;
        OFS_DEGLITCH_STATE: next_rdata = deglitch_state;
        OFS_IRQ_MASK:       next_rdata = change_irq_mask;
        OFS_IRQ_FLAGS:      next_rdata = change_irq_flags;
        default:            next_rdata = RST_ZERO;
      endcase
    end
  end

  // Pin drive from the owner; open-drain lines release instead of high
  always_comb begin
    drv_val = (ctrl_owns_in & output_data_state)
            | (~ctrl_owns_in & periph_data_in);
    drv_en  = ((ctrl_owns_in & ctrl_oe_in) | (~ctrl_owns_in & periph_oe_in))
            & LINE_MASK;
    next_pin_oe_n = ~(drv_en & ~(open_drain_state & drv_val));
    next_pin_out  = drv_val & ~open_drain_state;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      output_data_state     <= RST_OUT_DATA;
      write_mask_state      <= RST_WMASK;
      open_drain_state      <= RST_OD;
      deglitch_state        <= RST_DEGLITCH;
      change_irq_mask       <= RST_IRQ_MASK;
      change_irq_flags      <= RST_FLAGS;
      level_prev            <= RST_ZERO;
      rdata_out             <= RST_ZERO;
      irq_out               <= 1'b0;
      pin_out               <= RST_ZERO;
      pin_oe_n_out          <= ~RST_ZERO;
      output_data_state_out <= RST_OUT_DATA;
    end else begin
      output_data_state     <= next_output_data_state;
      write_mask_state      <= next_write_mask_state;
      open_drain_state      <= next_open_drain_state;
      deglitch_state        <= next_deglitch_state;
      change_irq_mask       <= next_change_irq_mask;
      change_irq_flags      <= next_change_irq_flags;
      level_prev            <= next_level_prev;
      rdata_out             <= next_rdata;
      irq_out               <= next_irq;
      pin_out               <= next_pin_out;
      pin_oe_n_out          <= next_pin_oe_n;
      output_data_state_out <= next_output_data_state;
    end
  end

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_out_write;
    wr_in && (addr_in == OFS_OUT_DATA);
  endsequence

  sequence s_flags_read;
    rd_in && (addr_in == OFS_IRQ_FLAGS);
  endsequence

  sequence s_clock_off;
    !clk_en_in;
  endsequence

  AST_MASKED_WRITE: assert property (
    s_out_write |=> output_data_state ==
      (($past(output_data_state) & ~$past(write_mask_state))
       | ($past(wdata_in) & $past(write_mask_state) & LINE_MASK)))
    else $error("masked output write wrong");

  AST_WMASK_SET: assert property (
    wr_in && (addr_in == OFS_WMASK_SET) |=>
      ((write_mask_state & $past(wdata_in) & LINE_MASK)
       == ($past(wdata_in) & LINE_MASK)))
    else $error("write mask set missing");

  AST_WMASK_RESET: assert property (
    $rose(rst_n_in) |-> (write_mask_state == RST_WMASK))
    else $error("write mask not cleared by reset");

  AST_OD_NO_HIGH: assert property (
    ##1 ((~pin_oe_n_out & pin_out & $past(open_drain_state)) == RST_ZERO))
    else $error("open-drain line driven high");

  AST_OD_CLEAR: assert property (
    wr_in && (addr_in == OFS_OD_CLEAR) |=>
      ((open_drain_state & $past(wdata_in)) == RST_ZERO))
    else $error("open-drain clear missing");

  AST_LEVEL_FROZEN: assert property (
    s_clock_off |=> $stable(pin_level_state))
    else $error("pin level moved with clock off");

  AST_NO_CHANGE_OFF: assert property (
    s_clock_off ##1 s_clock_off |-> $stable(change_irq_flags) || $past(rd_flags))
    else $error("change flagged with clock off");

  AST_FLAGS_READ: assert property (
    s_flags_read |=> change_irq_flags == $past(change))
    else $error("flags not cleared by read");

  AST_IRQ_OR: assert property (
    ##1 (irq_out == |(change_irq_flags & change_irq_mask)))
    else $error("irq not OR of masked flags");

  AST_CHANGE_SETS: assert property (
    (change != RST_ZERO) |=> ((change_irq_flags & $past(change)) == $past(change)))
    else $error("change did not set flag");

  sequence s_level_read;
    rd_in && (addr_in == OFS_PIN_LEVEL);
  endsequence

  AST_WMASK_CLEAR: assert property (
    wr_in && (addr_in == OFS_WMASK_CLEAR) |=>
      ((write_mask_state & $past(wdata_in)) == RST_ZERO))
    else $error("write mask clear missing");

  AST_OD_RESET: assert property (
    $rose(rst_n_in) |-> (open_drain_state == RST_OD))
    else $error("open drain not cleared by reset");

  AST_OD_SET: assert property (
    wr_in && (addr_in == OFS_OD_SET) |=>
      ((open_drain_state & $past(wdata_in) & LINE_MASK) == ($past(wdata_in) & LINE_MASK)))
    else $error("open-drain set missing");

  AST_DEGLITCH_SET: assert property (
    wr_in && (addr_in == OFS_DEGLITCH_SET) |=>
      ((deglitch_state & $past(wdata_in) & LINE_MASK) == ($past(wdata_in) & LINE_MASK)))
    else $error("deglitch set missing");

  AST_DEGLITCH_CLEAR: assert property (
    wr_in && (addr_in == OFS_DEGLITCH_CLEAR) |=>
      ((deglitch_state & $past(wdata_in)) == RST_ZERO))
    else $error("deglitch clear missing");

  AST_IRQ_MASK_SET: assert property (
    wr_in && (addr_in == OFS_IRQ_SET) |=>
      ((change_irq_mask & $past(wdata_in) & LINE_MASK) == ($past(wdata_in) & LINE_MASK)))
    else $error("irq mask set missing");

  AST_IRQ_MASK_CLEAR: assert property (
    wr_in && (addr_in == OFS_IRQ_CLEAR) |=>
      ((change_irq_mask & $past(wdata_in)) == RST_ZERO))
    else $error("irq mask clear missing");

  AST_DRIVE_HIGH: assert property (
    wr_in && (addr_in == OFS_DRIVE_HIGH) |=>
      (output_data_state == ($past(output_data_state) | ($past(wdata_in) & LINE_MASK))))
    else $error("drive high write missing");

  AST_DRIVE_LOW: assert property (
    wr_in && (addr_in == OFS_DRIVE_LOW) |=>
      (output_data_state == ($past(output_data_state) & ~($past(wdata_in) & LINE_MASK))))
    else $error("drive low write missing");

  AST_LEVEL_READ: assert property (
    s_level_read |=> (rdata_out == ($past(pin_level_state) & LINE_MASK)))
    else $error("pin level read wrong");

endmodule // gmf_port

// file: bench/gmf_pin_model.sv
// Far-side pin model: external drivers plus a pull-up on every line.
// Assumes the bench steers the external enables and values.
`timescale 1ns/1ns
module gmf_pin_model (
  // Device side
  input  wire logic [31:0] dut_out_in,
  input  wire logic [31:0] dut_oe_n_in,
  // External drivers
  input  wire logic [31:0] ext_oe_in,
  input  wire logic [31:0] ext_val_in,
  // Resolved level
  output logic      [31:0] pin_level_out
);
  // shared line, pulled up
  // Any party driving low wins; a released line floats to the pull-up
  assign pin_level_out = (dut_oe_n_in | dut_out_in) & (~ext_oe_in | ext_val_in);
endmodule // gmf_pin_model

// file: bench/gmf_port_tb_top.sv
// Self-checking bench for the 32-line port controller.
// Assumes the pin model as the only far-side party.
`timescale 1ns/1ns
module gmf_port_tb_top;
  import gmf_pkg::*;
  logic        clk_in, rst_n_in, clk_en, wr, rd, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, owns, coe, poe, pdata;
  logic [31:0] pin, pout, poe_n, ods, ext_oe, ext_val;
  int          err_count, checks, cyc;

  gmf_port gmf_port_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .ctrl_owns_in(owns), .ctrl_oe_in(coe), .periph_oe_in(poe), .periph_data_in(pdata),
    .pin_in(pin), .pin_out(pout), .pin_oe_n_out(poe_n),
    .output_data_state_out(ods), .irq_out(irq));
  gmf_pin_model gmf_pin_model_inst (.dut_out_in(pout), .dut_oe_n_in(poe_n),
    .ext_oe_in(ext_oe), .ext_val_in(ext_val), .pin_level_out(pin));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 150 cycles the tests need
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      finish_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(nm, v, exp);
  endtask

  task automatic st(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic t_reset;
    rd_chk("wmask", OFS_WMASK_STATE, RST_WMASK);
    rd_chk("od", OFS_OD_STATE, RST_OD);
    rd_chk("deglitch", OFS_DEGLITCH_STATE, RST_DEGLITCH);
    rd_chk("irq_mask", OFS_IRQ_MASK, RST_IRQ_MASK);
    rd_chk("out_data", OFS_OUT_DATA, RST_OUT_DATA);
    wr_reg(8'hFC, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'hFC, RST_ZERO);
    rd_chk("write_only", OFS_DRIVE_HIGH, RST_ZERO);
    $display("test reset done");
  endtask

  task automatic t_out;
    wr_reg(OFS_DRIVE_HIGH, 32'hF0F0F0F0);
    wr_reg(OFS_DRIVE_LOW, 32'h30000000);
    st(1);
    chk("ods", ods, 32'hC0F0F0F0);
    wr_reg(OFS_WMASK_SET, 32'h0000FFFF);
    wr_reg(OFS_WMASK_CLEAR, 32'h000000FF);
    rd_chk("wmask", OFS_WMASK_STATE, 32'h0000FF00);
    wr_reg(OFS_OUT_DATA, 32'h0F0F0F0F);
    st(1);
    chk("ods_masked", ods, 32'hC0F00FF0);
    rd_chk("out_data", OFS_OUT_DATA, 32'hC0F00FF0);
    $display("test output data done");
  endtask

  task automatic t_od;
    logic [31:0] od;
    od = 32'h0000001F;
    @(posedge clk_in);
    owns <= 32'hFFFFFFEF;
    coe <= 32'hFFFFFFFF;
    poe <= 32'h00000010;
    pdata <= 32'h00000010;
    wr_reg(OFS_OD_SET, od);
    rd_chk("od", OFS_OD_STATE, od);
    st(2);
    // Lines 0-3 pulled low, line 4 released to the pull-up, rest driven
    chk("oe_n", poe_n, 32'h00000010);
    chk("pin_out", pout, 32'hC0F00FE0);
    chk("pin_od", pin, 32'hC0F00FF0);
    wr_reg(OFS_OD_CLEAR, 32'hFFFFFFFF);
    rd_chk("od_clr", OFS_OD_STATE, RST_ZERO);
    coe <= 32'h0;
    poe <= 32'h0;
    $display("test open drain done");
  endtask

  task automatic t_pin;
    logic [31:0] v;
    @(posedge clk_in);
    ext_oe <= 32'hFFFFFFFF;
    ext_val <= 32'hA5A55A5A;
    st(8);
    rd_chk("level", OFS_PIN_LEVEL, 32'hA5A55A5A);
    rd_reg(OFS_IRQ_FLAGS, v);
    clk_en <= 1'b0;
    ext_val <= 32'h5A5A0F0F;
    st(8);
    rd_chk("level_frozen", OFS_PIN_LEVEL, 32'hA5A55A5A);
    rd_chk("flags_off", OFS_IRQ_FLAGS, RST_ZERO);
    clk_en <= 1'b1;
    st(8);
    rd_chk("level_new", OFS_PIN_LEVEL, 32'h5A5A0F0F);
    rd_chk("flags_all", OFS_IRQ_FLAGS, 32'hFFFF5555);
    $display("test pin level done");
  endtask

  task automatic t_irq;
    @(posedge clk_in);
    owns <= 32'hFFFFFFFD;
    wr_reg(OFS_IRQ_SET, 32'h00000003);
    wr_reg(OFS_IRQ_CLEAR, 32'h00000002);
    rd_chk("irq_mask", OFS_IRQ_MASK, 32'h00000001);
    ext_val <= ext_val ^ 32'h2;
    st(8);
    chk("irq_unmasked", {31'h0, irq}, 32'h0);
    ext_val <= ext_val ^ 32'h1;
    st(8);
    chk("irq_masked", {31'h0, irq}, 32'h1);
    rd_chk("flags", OFS_IRQ_FLAGS, 32'h00000003);
    st(1);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    rd_chk("flags_clr", OFS_IRQ_FLAGS, RST_ZERO);
    $display("test irq done");
  endtask

  task automatic t_filt;
    wr_reg(OFS_DEGLITCH_SET, 32'h00000100);
    rd_chk("deglitch", OFS_DEGLITCH_STATE, 32'h00000100);
    // Short pulse straddling a rising edge
    @(negedge clk_in);
    #15 ext_val[8] = ~ext_val[8];
    #10 ext_val[8] = ~ext_val[8];
    st(8);
    rd_chk("glitch", OFS_IRQ_FLAGS, RST_ZERO);
    ext_val <= ext_val ^ 32'h100;
    st(3);
    ext_val <= ext_val ^ 32'h100;
    st(8);
    rd_chk("pulse", OFS_IRQ_FLAGS, 32'h00000100);
    wr_reg(OFS_DEGLITCH_CLEAR, 32'hFFFFFFFF);
    rd_chk("deglitch_clr", OFS_DEGLITCH_STATE, RST_ZERO);
    $display("test filter done");
  endtask

  initial begin
    {wr, rd, addr, wdata, poe, pdata, ext_oe, ext_val, coe} = '0;
    {err_count, checks, cyc} = '0;
    owns = 32'hFFFFFFFF;
    rst_n_in = 1'b0;
    clk_en = 1'b1;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_out;
    t_od;
    t_pin;
    t_irq;
    t_filt;
    finish_test;
  end
endmodule // gmf_port_tb_top
